//--- hdl/pio_ports.sv
// parallel port block timed by the instruction cycle sequencer
`default_nettype none
module pio_ports
   import pio_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic DUAL_CLK_MODE,
   input wire logic INSN_REQ,
   input wire logic [1:0] INSN_OP,
   input wire logic [1:0] INSN_LEN,
   input wire logic [3:0] INSN_ADDR,
   input wire logic [3:0] INSN_WDATA,
   output logic INSN_READY,
   output logic INSN_DONE,
   output logic [3:0] INSN_RDATA,
   output logic [1:0] CYCLE_STATE,
   input wire logic [3:0] KEY_INPUT_PORT,
   output logic [3:0] OUT_PORT_A,
   output logic [3:0] OUT_PORT_B,
   output logic [3:0] OUT_PORT_C,
   output logic [3:0] OUT_PORT_D,
   input wire logic [3:0] ANALOG_SHARED_PORT_A_IN,
   output logic [3:0] ANALOG_SHARED_PORT_A_OUT,
   output logic [3:0] ANALOG_SHARED_PORT_A_OE,
   input wire logic [3:0] ANALOG_SHARED_PORT_B_IN,
   output logic [3:0] ANALOG_SHARED_PORT_B_OUT,
   output logic [3:0] ANALOG_SHARED_PORT_B_OE,
   input wire logic [3:0] PLAIN_BIDIR_PORT_IN,
   output logic [3:0] PLAIN_BIDIR_PORT_OUT,
   output logic [3:0] PLAIN_BIDIR_PORT_OE,
   input wire logic [3:0] RESONATOR_SHARED_PORT_IN,
   output logic [3:0] RESONATOR_SHARED_PORT_OUT,
   output logic [3:0] RESONATOR_SHARED_PORT_OE,
   input wire logic [3:0] INTERRUPT_SHARED_PORT_IN,
   output logic [3:0] INTERRUPT_SHARED_PORT_OUT,
   output logic [3:0] INTERRUPT_SHARED_PORT_OE,
   input wire logic [2:0] SERIAL_SHARED_PORT_IN,
   output logic [2:0] SERIAL_SHARED_PORT_OUT,
   output logic [2:0] SERIAL_SHARED_PORT_OE,
   input wire logic [3:0] GENERAL_PORT_A_IN,
   output logic [3:0] GENERAL_PORT_A_OUT,
   output logic [3:0] GENERAL_PORT_A_OE,
   input wire logic [3:0] GENERAL_PORT_B_IN,
   output logic [3:0] GENERAL_PORT_B_OUT,
   output logic [3:0] GENERAL_PORT_B_OE,
   input wire logic [3:0] GENERAL_PORT_C_IN,
   output logic [3:0] GENERAL_PORT_C_OUT,
   output logic [3:0] GENERAL_PORT_C_OE
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic is_out_only(input logic [3:0] a);
      is_out_only = (a >= ADDR_OUT_A) && (a <= ADDR_OUT_D);
   endfunction : is_out_only

   function automatic logic is_writable(input logic [3:0] a);
      is_writable = (a != ADDR_KEY) && (a <= ADDR_LAST);
   endfunction : is_writable

   typedef struct packed {
      logic [NPORT-1:0][PW-1:0] s1;
      logic [NPORT-1:0][PW-1:0] s2;
      logic [NPORT-1:0][PW-1:0] lat;
      logic busy;
      logic [1:0] len;
      logic [1:0] cyc;
      pio_op_t op;
      logic [3:0] addr;
      logic [3:0] wdata;
      logic [3:0] rdata;
      logic done;
   } pio_core_t;

   pio_core_t q, d;
   logic [POS_W-1:0] pos;
   pio_state_t state;
   logic cycle_end;
   logic [NPORT-1:0][PW-1:0] pin_raw;
   logic [3:0] osc_mask;
   logic last_cycle;

   // ----------------------------------------------------------------
   // cycle sequencer
   // ----------------------------------------------------------------
   pio_seq u_seq (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .pos(pos),
      .state(state),
      .cycle_end(cycle_end)
   );

   // ----------------------------------------------------------------
   // pin gathering; output-only slots carry no pins
   // ----------------------------------------------------------------
   always_comb begin
      pin_raw = '0;
      pin_raw[ADDR_KEY] = KEY_INPUT_PORT;
      pin_raw[ADDR_ANALOG_A] = ANALOG_SHARED_PORT_A_IN;
      pin_raw[ADDR_ANALOG_B] = ANALOG_SHARED_PORT_B_IN;
      pin_raw[ADDR_PLAIN] = PLAIN_BIDIR_PORT_IN;
      pin_raw[ADDR_RESON] = RESONATOR_SHARED_PORT_IN;
      pin_raw[ADDR_INTR] = INTERRUPT_SHARED_PORT_IN;
      pin_raw[ADDR_SERIAL] = {1'b0, SERIAL_SHARED_PORT_IN};
      pin_raw[ADDR_GEN_A] = GENERAL_PORT_A_IN;
      pin_raw[ADDR_GEN_B] = GENERAL_PORT_B_IN;
      pin_raw[ADDR_GEN_C] = GENERAL_PORT_C_IN;
   end

   // oscillator pins leave port duty only in dual-clock mode
   assign osc_mask = DUAL_CLK_MODE ? RESON_OSC_MASK : NIB_ZERO;
   assign last_cycle = (q.cyc == (q.len - 2'h1));

   // ----------------------------------------------------------------
   // instruction execution
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.s1 = pin_raw;
      d.s2 = q.s1;
      d.done = 1'b0;
      if (q.busy) begin
         // sample once, at the opening clock of the third state
         if (q.op == PIO_OP_INPUT && q.cyc == IO_ACT_CYCLE && pos == POS_SAMPLE) begin
            if (is_out_only(q.addr)) begin
               d.rdata = q.lat[q.addr];
            end else if (q.addr == ADDR_RESON) begin
               d.rdata = q.s2[q.addr] & ~osc_mask;
            end else if (q.addr <= ADDR_LAST) begin
               d.rdata = q.s2[q.addr]; // no filtering, software must debounce
            end else begin
               d.rdata = NIB_ZERO;
            end
         end
         if (q.op == PIO_OP_OUTPUT && q.cyc == IO_ACT_CYCLE && pos == POS_DRIVE
             && is_writable(q.addr)) begin
            d.lat[q.addr] = (q.addr == ADDR_SERIAL) ? (q.wdata & SERIAL_MASK) : q.wdata;
         end
         if (cycle_end) begin
            d.cyc = q.cyc + 2'h1;
            if (last_cycle) begin
               d.busy = 1'b0;
               d.done = 1'b1;
            end
         end
      end
      // a new instruction always opens at the first state of a cycle
      if (INSN_READY && INSN_REQ) begin
         d.busy = 1'b1;
         d.cyc = 2'h0;
         d.op = pio_op_t'(INSN_OP);
         d.addr = INSN_ADDR;
         d.wdata = INSN_WDATA;
         if (INSN_OP == PIO_OP_INPUT || INSN_OP == PIO_OP_OUTPUT) begin
            d.len = LEN_IO;
         end else if (INSN_LEN == 2'h0) begin
            d.len = LEN_MIN; // zero length is clamped up
         end else begin
            d.len = INSN_LEN;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         q.s1 <= '0;
         q.s2 <= '0;
         q.lat <= {NPORT{LATCH_RST}};
         q.busy <= 1'b0;
         q.len <= LEN_MIN;
         q.cyc <= 2'h0;
         q.op <= PIO_OP_OTHER;
         q.addr <= NIB_ZERO;
         q.wdata <= NIB_ZERO;
         q.rdata <= NIB_ZERO;
         q.done <= 1'b0;
      end else begin
         q <= d; // latches change only on an output write
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign INSN_READY = cycle_end && (!q.busy || last_cycle);
   assign INSN_DONE = q.done;
   assign INSN_RDATA = q.rdata;
   assign CYCLE_STATE = state;

   assign OUT_PORT_A = q.lat[ADDR_OUT_A];
   assign OUT_PORT_B = q.lat[ADDR_OUT_B];
   assign OUT_PORT_C = q.lat[ADDR_OUT_C];
   assign OUT_PORT_D = q.lat[ADDR_OUT_D];

   // open-drain style: a latched zero pulls low (not on the oscillator pins in dual-clock mode), a one releases for input
   assign ANALOG_SHARED_PORT_A_OUT = q.lat[ADDR_ANALOG_A];
   assign ANALOG_SHARED_PORT_A_OE = ~q.lat[ADDR_ANALOG_A];
   assign ANALOG_SHARED_PORT_B_OUT = q.lat[ADDR_ANALOG_B];
   assign ANALOG_SHARED_PORT_B_OE = ~q.lat[ADDR_ANALOG_B];
   assign PLAIN_BIDIR_PORT_OUT = q.lat[ADDR_PLAIN];
   assign PLAIN_BIDIR_PORT_OE = ~q.lat[ADDR_PLAIN];
   assign RESONATOR_SHARED_PORT_OUT = q.lat[ADDR_RESON];
   assign RESONATOR_SHARED_PORT_OE = ~q.lat[ADDR_RESON] & ~osc_mask;
   assign INTERRUPT_SHARED_PORT_OUT = q.lat[ADDR_INTR];
   assign INTERRUPT_SHARED_PORT_OE = ~q.lat[ADDR_INTR];
   assign SERIAL_SHARED_PORT_OUT = q.lat[ADDR_SERIAL][2:0];
   assign SERIAL_SHARED_PORT_OE = ~q.lat[ADDR_SERIAL][2:0];
   assign GENERAL_PORT_A_OUT = q.lat[ADDR_GEN_A];
   assign GENERAL_PORT_A_OE = ~q.lat[ADDR_GEN_A];
   assign GENERAL_PORT_B_OUT = q.lat[ADDR_GEN_B];
   assign GENERAL_PORT_B_OE = ~q.lat[ADDR_GEN_B];
   assign GENERAL_PORT_C_OUT = q.lat[ADDR_GEN_C];
   assign GENERAL_PORT_C_OE = ~q.lat[ADDR_GEN_C];
endmodule : pio_ports
`default_nettype wire

//--- hdl/pio_pkg.sv
// constants and types shared by the port block and its cycle sequencer
`default_nettype none
package pio_pkg;
   // ----------------------------------------------------------------
   // instruction cycle timing
   // ----------------------------------------------------------------
   localparam int unsigned POS_W = 3;
   localparam logic [POS_W-1:0] POS_LAST = 3'h7;
   localparam logic [POS_W-1:0] POS_SAMPLE = 3'h4;
   localparam logic [POS_W-1:0] POS_DRIVE = 3'h6;
   localparam int unsigned CLK_PER_STATE_LOG2 = 1;

   typedef enum logic [1:0] {
      PIO_STATE_ONE = 2'b00,
      PIO_STATE_TWO = 2'b01,
      PIO_STATE_THREE = 2'b10,
      PIO_STATE_FOUR = 2'b11
   } pio_state_t;

   // ----------------------------------------------------------------
   // instruction kinds and lengths
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PIO_OP_OTHER = 2'b00,
      PIO_OP_INPUT = 2'b01,
      PIO_OP_OUTPUT = 2'b10
   } pio_op_t;

   localparam logic [1:0] LEN_MIN = 2'h1;
   localparam logic [1:0] LEN_IO = 2'h2;
   localparam logic [1:0] IO_ACT_CYCLE = 2'h1;

   // ----------------------------------------------------------------
   // port addresses and layout
   // ----------------------------------------------------------------
   localparam int unsigned NPORT = 15;
   localparam int unsigned PW = 4;
   localparam logic [3:0] ADDR_KEY = 4'h0;
   localparam logic [3:0] ADDR_OUT_A = 4'h1;
   localparam logic [3:0] ADDR_OUT_B = 4'h2;
   localparam logic [3:0] ADDR_OUT_C = 4'h3;
   localparam logic [3:0] ADDR_OUT_D = 4'h4;
   localparam logic [3:0] ADDR_ANALOG_A = 4'h5;
   localparam logic [3:0] ADDR_ANALOG_B = 4'h6;
   localparam logic [3:0] ADDR_PLAIN = 4'h7;
   localparam logic [3:0] ADDR_RESON = 4'h8;
   localparam logic [3:0] ADDR_INTR = 4'h9;
   localparam logic [3:0] ADDR_SERIAL = 4'ha;
   localparam logic [3:0] ADDR_GEN_A = 4'hb;
   localparam logic [3:0] ADDR_GEN_B = 4'hc;
   localparam logic [3:0] ADDR_GEN_C = 4'hd;
   localparam logic [3:0] ADDR_LAST = 4'hd;
   localparam logic [3:0] SERIAL_MASK = 4'h7;
   localparam logic [3:0] RESON_OSC_MASK = 4'hc;
   localparam logic [3:0] LATCH_RST = 4'hf;
   localparam logic [3:0] NIB_ZERO = 4'h0;
endpackage : pio_pkg
`default_nettype wire

//--- hdl/pio_seq.sv
// instruction cycle sequencer: four states of two basic clocks each
`default_nettype none
module pio_seq
   import pio_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   output logic [POS_W-1:0] pos,
   output pio_state_t state,
   output logic cycle_end
);
   typedef struct packed {
      logic [POS_W-1:0] pos;
   } pio_seq_st_t;

   pio_seq_st_t q, d;

   // ----------------------------------------------------------------
   // free running position inside the cycle
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.pos = q.pos + 3'h1; // wraps after eight clocks
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q.pos <= 3'h0;
      end else begin
         q <= d;
      end
   end

   assign pos = q.pos;
   assign state = pio_state_t'(q.pos[POS_W-1:CLK_PER_STATE_LOG2]);
   assign cycle_end = (q.pos == POS_LAST);
endmodule : pio_seq
`default_nettype wire

//--- test/pio_ports_asserts.sv
// timing and pin-drive checks on the port block pins
`default_nettype none
module pio_ports_asserts
   import pio_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic DUAL_CLK_MODE,
   input wire logic INSN_REQ,
   input wire logic [1:0] INSN_OP,
   input wire logic [1:0] INSN_LEN,
   input wire logic INSN_READY,
   input wire logic INSN_DONE,
   input wire logic [3:0] INSN_RDATA,
   input wire logic [1:0] CYCLE_STATE,
   input wire logic [3:0] OUT_PORT_A,
   input wire logic [3:0] RESONATOR_SHARED_PORT_OUT,
   input wire logic [3:0] RESONATOR_SHARED_PORT_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   logic tk;
   logic io;
   assign tk = INSN_READY && INSN_REQ;
   assign io = INSN_OP == PIO_OP_INPUT || INSN_OP == PIO_OP_OUTPUT;
   // ----------
   // checks
   // ----------
   // reset jumps the state, so the first edge after it is skipped
   state_hold_a: assert property ($changed(CYCLE_STATE) |=> $stable(CYCLE_STATE))
      else $error("state lasted one clock");
   state_step_a: assert property (!$past(SYS_RST) && $changed(CYCLE_STATE)
      |-> CYCLE_STATE == $past(CYCLE_STATE) + 2'h1) else $error("state order broken");
   ready_slot_a: assert property (INSN_READY |-> CYCLE_STATE == PIO_STATE_FOUR
      && $past(CYCLE_STATE) == PIO_STATE_FOUR) else $error("ready off cycle end");
   io_len_a: assert property (tk && io |-> ##17 INSN_DONE ##1 !INSN_DONE)
      else $error("port op not two cycles");
   short_len_a: assert property (tk && INSN_OP == PIO_OP_OTHER && INSN_LEN == 2'h0
      |-> ##9 INSN_DONE) else $error("short op length wrong");
   long_len_a: assert property (tk && INSN_OP == PIO_OP_OTHER && INSN_LEN == 2'h3
      |-> ##2 !INSN_DONE [*8] ##16 INSN_DONE) else $error("long op length wrong");
   sample_slot_a: assert property (!$past(SYS_RST) && $changed(INSN_RDATA)
      |-> CYCLE_STATE == PIO_STATE_THREE) else $error("input sampled off slot");
   drive_slot_a: assert property (!$past(SYS_RST) && $changed(OUT_PORT_A)
      |-> CYCLE_STATE == PIO_STATE_FOUR) else $error("output driven off slot");
   osc_pins_a: assert property ($past(DUAL_CLK_MODE) && DUAL_CLK_MODE
      |-> RESONATOR_SHARED_PORT_OE[3:2] == 2'b00) else $error("oscillator pins driven");
   plain_bits_a: assert property (!$past(DUAL_CLK_MODE) && !DUAL_CLK_MODE
      |-> RESONATOR_SHARED_PORT_OE == ~RESONATOR_SHARED_PORT_OUT) else $error("port bits off");
   in_c: cover property (tk && INSN_OP == PIO_OP_INPUT);
   out_c: cover property (tk && INSN_OP == PIO_OP_OUTPUT);
   dual_c: cover property (tk && DUAL_CLK_MODE);
endmodule : pio_ports_asserts
bind pio_ports pio_ports_asserts chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
   .DUAL_CLK_MODE(DUAL_CLK_MODE), .INSN_REQ(INSN_REQ), .INSN_OP(INSN_OP),
   .INSN_LEN(INSN_LEN), .INSN_READY(INSN_READY), .INSN_DONE(INSN_DONE),
   .INSN_RDATA(INSN_RDATA), .CYCLE_STATE(CYCLE_STATE), .OUT_PORT_A(OUT_PORT_A),
   .RESONATOR_SHARED_PORT_OUT(RESONATOR_SHARED_PORT_OUT),
   .RESONATOR_SHARED_PORT_OE(RESONATOR_SHARED_PORT_OE));
`default_nettype wire

//--- test/pio_pins_model.sv
// outside circuitry on the bidirectional pins
`default_nettype none
module pio_pins_model #(
   parameter int W = 35
) (
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] dout,
   input wire logic [W-1:0] ext,
   output logic [W-1:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // wire level
   // ----------
   // released bits follow the outside driver, so a stale latch value never shows
   assign pin = (oe & dout) | (~oe & ext);
endmodule : pio_pins_model
`default_nettype wire

//--- test/port_io_cycle_timing_bench.sv
// self-checking bench for the port block
`default_nettype none
module port_io_cycle_timing_bench import pio_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, dual = 0, req = 0;
   logic [1:0] op = 2'h0, len = 2'h0;
   logic [3:0] addr = 4'h0, wd = 4'h0;
   logic [35:0] ext = 36'h0;
   logic [3:0] lat [16];
   logic [31:0] seed = 32'h225b;
   wire rdy, done;
   wire [1:0] cst;
   wire [3:0] rd;
   wire [15:0] outp;
   wire [34:0] pin, po, oe;
   int fail_count = 0, cmp_count = 0, n;
   initial begin
      forever #5 clk = ~clk;
   end
   pio_ports dut (.REF_CLK(clk), .SYS_RST(rst), .DUAL_CLK_MODE(dual), .INSN_REQ(req),
      .INSN_OP(op), .INSN_LEN(len), .INSN_ADDR(addr), .INSN_WDATA(wd), .INSN_READY(rdy),
      .INSN_DONE(done), .INSN_RDATA(rd), .CYCLE_STATE(cst), .KEY_INPUT_PORT(ext[35:32]),
      .OUT_PORT_A(outp[3:0]), .OUT_PORT_B(outp[7:4]), .OUT_PORT_C(outp[11:8]),
      .OUT_PORT_D(outp[15:12]), .ANALOG_SHARED_PORT_A_IN(pin[3:0]),
      .ANALOG_SHARED_PORT_A_OUT(po[3:0]), .ANALOG_SHARED_PORT_A_OE(oe[3:0]),
      .ANALOG_SHARED_PORT_B_IN(pin[7:4]), .ANALOG_SHARED_PORT_B_OUT(po[7:4]),
      .ANALOG_SHARED_PORT_B_OE(oe[7:4]), .PLAIN_BIDIR_PORT_IN(pin[11:8]),
      .PLAIN_BIDIR_PORT_OUT(po[11:8]), .PLAIN_BIDIR_PORT_OE(oe[11:8]),
      .RESONATOR_SHARED_PORT_IN(pin[15:12]), .RESONATOR_SHARED_PORT_OUT(po[15:12]),
      .RESONATOR_SHARED_PORT_OE(oe[15:12]), .INTERRUPT_SHARED_PORT_IN(pin[19:16]),
      .INTERRUPT_SHARED_PORT_OUT(po[19:16]), .INTERRUPT_SHARED_PORT_OE(oe[19:16]),
      .GENERAL_PORT_A_IN(pin[23:20]), .GENERAL_PORT_A_OUT(po[23:20]),
      .GENERAL_PORT_A_OE(oe[23:20]), .GENERAL_PORT_B_IN(pin[27:24]),
      .GENERAL_PORT_B_OUT(po[27:24]), .GENERAL_PORT_B_OE(oe[27:24]),
      .GENERAL_PORT_C_IN(pin[31:28]), .GENERAL_PORT_C_OUT(po[31:28]),
      .GENERAL_PORT_C_OE(oe[31:28]), .SERIAL_SHARED_PORT_IN(pin[34:32]),
      .SERIAL_SHARED_PORT_OUT(po[34:32]), .SERIAL_SHARED_PORT_OE(oe[34:32]));
   pio_pins_model #(.W(35)) far (.oe(oe), .dout(po), .ext(ext[34:0]), .pin(pin));
   // ----------
   // helpers
   // ----------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [34:0] exp_po();
      return {lat[10][2:0], lat[13], lat[12], lat[11], lat[9], lat[8], lat[7], lat[6], lat[5]};
   endfunction : exp_po
   function automatic logic [3:0] exp_rd(logic [3:0] a);
      logic [35:0] p;
      logic [3:0] v;
      int off;
      p = {ext[35], exp_po() & ext[34:0]};
      if (a == 4'h0) return ext[35:32];
      if (a < 4'h5) return lat[a];
      if (a > 4'hd) return 4'h0;
      off = (a == 4'ha) ? 32 : (a < 4'ha) ? (a - 5) * 4 : (a - 6) * 4;
      v = p[off+:4] & ((a == 4'ha) ? 4'h7 : 4'hf);
      if (a == 4'h8 && dual) v[3:2] = 2'b00;
      return v;
   endfunction : exp_rd
   task automatic check(logic [63:0] got, logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic check_pins();
      logic [34:0] m;
      // sized here: inverted inside a 64-bit argument the upper bits would turn to ones
      m = ~exp_po() & ~(dual ? 35'h0c000 : 35'h0);
      check(outp, {lat[4], lat[3], lat[2], lat[1]});
      check(po, exp_po());
      check(oe, m);
   endtask : check_pins
   task automatic do_reset(int c);
      rst = 1;
      repeat (c) @(negedge clk);
      rst = 0;
      foreach (lat[i]) lat[i] = 4'hf;
      check({done, rd, cst}, 7'h0);
      check_pins();
   endtask : do_reset
   // one instruction; waits for the cycle boundary, then times the done pulse
   task automatic run(logic [1:0] o, logic [1:0] l, logic [3:0] a, logic [3:0] w);
      logic [3:0] e;
      int k;
      k = 8 * ((o == 2'h1 || o == 2'h2) ? 2 : (l == 2'h0) ? 1 : int'(l)) + 1;
      op = o;
      len = l;
      addr = a;
      wd = w;
      req = 1;
      n = 0;
      while (!rdy && n < 20) begin
         @(negedge clk);
         n++;
      end
      e = exp_rd(a);
      n = 0;
      do begin
         @(negedge clk);
         req = 0;
         n++;
      end while (!done && n < 40);
      check(n, k);
      if (o == 2'h1) check(rd, e);
      if (o == 2'h2 && a != 4'h0 && a < 4'he) lat[a] = w & ((a == 4'ha) ? 4'h7 : 4'hf);
      check_pins();
   endtask : run
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   // ----------
   // tests
   // ----------
   initial begin
      logic [31:0] r;
      do_reset(16);
      $display("reset values checked");
      for (int a = 0; a < 16; a++) begin
         run(2'h2, 2'h0, a[3:0], a[3:0] ^ 4'h6);
         ext = {rnd(), 4'h9};
         run(2'h1, 2'h3, a[3:0], 4'h0);
      end
      $display("port sweep done");
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         ext = {r[3:0], rnd()};
         dual = r[31] & r[30];
         run(r[5:4], r[7:6], r[11:8], r[15:12]);
      end
      $display("random run done");
      do_reset(2);
      run(2'h1, 2'h0, 4'h7, 4'h0);
      // dual mode: oscillator bits released and read back as zero
      dual = 1;
      ext = {4'h5, 32'hfffff3a6};
      run(2'h2, 2'h0, 4'h8, 4'h2);
      run(2'h1, 2'h0, 4'h8, 4'h0);
      $display("second reset done");
      end_of_test();
   end
   initial begin
      #100us;
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule : port_io_cycle_timing_bench
`default_nettype wire
